// ---- acc_pkg.sv ----
// package for the analog comparator control block: register map, fields, carriers
package acc_pkg;
   // register byte offsets on the apb bus
   localparam logic [11:0] ADDR_CONTROL = 12'h000;
   localparam logic [11:0] ADDR_REF_SETUP = 12'h004;
   // comparator_control fields
   localparam int CTL_ENABLE = 7;
   localparam int CTL_RESULT = 6;
   localparam int CTL_TIMER_SAMPLE = 5;
   localparam int CTL_INVERT = 4;
   localparam int CTL_MINUS_HI = 3;
   localparam int CTL_MINUS_LO = 1;
   localparam int CTL_PLUS = 0;
   localparam logic [7:0] CTL_WRITE_MASK = 8'hBF;
   localparam logic [7:0] CTL_RESET = 8'h00;
   // comparator_reference_setup fields
   localparam int REF_PIN_OUT = 7;
   localparam int REF_WAKE_EN = 6;
   localparam int REF_RANGE_HI = 5;
   localparam int REF_RANGE_LO = 4;
   localparam int REF_STEP_HI = 3;
   localparam logic [7:0] REF_RESET = 8'h00;
   // minus input selections
   typedef enum logic [2:0] {
      ACC_MINUS_PIN_A = 3'h0,
      ACC_MINUS_PLUS_PIN = 3'h1,
      ACC_MINUS_BANDGAP = 3'h2,
      ACC_MINUS_LADDER = 3'h3,
      ACC_MINUS_PIN_C = 3'h4,
      ACC_MINUS_PIN_D = 3'h5
   } acc_minus_e;
   // ladder ranges: ratio = (step + offset) / denominator
   typedef enum logic [1:0] {
      ACC_RANGE_A = 2'h0,
      ACC_RANGE_B = 2'h1,
      ACC_RANGE_C = 2'h2,
      ACC_RANGE_D = 2'h3
   } acc_range_e;
   localparam logic [4:0] LAD_OFS_HIGH = 5'h09;
   localparam logic [4:0] LAD_OFS_LOW = 5'h01;
   localparam logic [5:0] LAD_DEN_A = 6'h20;
   localparam logic [5:0] LAD_DEN_B = 6'h18;
   localparam logic [5:0] LAD_DEN_C = 6'h28;
   localparam logic [5:0] LAD_DEN_D = 6'h20;
   // setup sent to the analog front end
   typedef struct packed {
      logic enable;
      acc_minus_e minusSel;
      logic plusSelPin;
      acc_range_e range;
      logic [3:0] step;
      logic [4:0] ratioNum;
      logic [5:0] ratioDen;
   } acc_analog_s;
   // apb request carrier
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } acc_apb_req_s;
endpackage

// ---- acc_comparator_control.sv ----
// analog comparator control: apb registers, result path, pin drive, interrupt and wake requests
//
// Functional notes
// - minus input picked from six sources by control bits 3..1.
// - plus input is ladder when control bit 0 is 0, pin when 1.
// - result polarity inverted while control bit 4 is set.
// - result drives output pin directly, or is sampled on timer clock tick.
// - rising edges of the result raise an interrupt request pulse.
// - control bit 7 enables the comparator; 0x80 gives pin-a minus, ladder plus.
// - range 00 gives ladder ratio (n+9)/32.
// - range 10 gives ratio (n+9)/40; minus code 011 picks the ladder.
// - wake request only when enable and wake-enable bits are both set.
`timescale 1ns/100ps
`default_nettype none
module acc_comparator_control
(
   input wire logic mclk,
   input wire logic arst_n,
   input wire acc_pkg::acc_apb_req_s apbReq,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic compRaw,
   input wire logic timer_b_sample_clock,
   input wire logic powerSave,
   output acc_pkg::acc_analog_s analogSetup,
   output logic comparator_output_pin,
   output logic comparatorPinOe,
   output logic compIrq,
   output logic wakeReq
);
   logic [7:0] ctlReg;
   logic [7:0] refReg;
   logic compMeta;
   logic compSync;
   logic heldResult;
   logic resultPrev;
   wire setupPhase = apbReq.psel && !apbReq.penable;
   wire accessDone = apbReq.psel && apbReq.penable && pready;
   // address decode
   wire hitCtl = (apbReq.paddr == acc_pkg::ADDR_CONTROL);
   wire hitRef = (apbReq.paddr == acc_pkg::ADDR_REF_SETUP);
   wire hitAny = hitCtl || hitRef;
   wire wrCtl = accessDone && apbReq.pwrite && hitCtl;
   wire wrRef = accessDone && apbReq.pwrite && hitRef;
   // result path
   wire compEnable = ctlReg[acc_pkg::CTL_ENABLE];
   wire polarResult = compSync ^ ctlReg[acc_pkg::CTL_INVERT];
   wire liveResult = compEnable && polarResult;
   wire timerMode = ctlReg[acc_pkg::CTL_TIMER_SAMPLE];
   wire next_heldResult = timer_b_sample_clock ? liveResult : heldResult;
   wire curResult = timerMode ? heldResult : liveResult;
   wire resultEdge = curResult && !resultPrev;
   // control register read view with the current result (held sample in timer mode)
   wire [7:0] ctlView = {ctlReg[7], curResult, ctlReg[5:0]};
   wire [7:0] next_ctl = apbReq.pwdata[7:0] & acc_pkg::CTL_WRITE_MASK;
   wire [7:0] readByte = hitCtl ? ctlView : (hitRef ? refReg : 8'h00);
   // ladder ratio for the selected range
   wire [1:0] rangeCode = refReg[acc_pkg::REF_RANGE_HI:acc_pkg::REF_RANGE_LO];
   wire [3:0] stepCode = refReg[acc_pkg::REF_STEP_HI:0];
   wire lowOfs = rangeCode[0];
   wire [4:0] next_num = {1'b0, stepCode} + (lowOfs ? acc_pkg::LAD_OFS_LOW
                                                    : acc_pkg::LAD_OFS_HIGH);
   logic [5:0] next_den;
   // denominator per range code
   always_comb
   begin
      case (acc_pkg::acc_range_e'(rangeCode))
         acc_pkg::ACC_RANGE_A: next_den = acc_pkg::LAD_DEN_A;
         acc_pkg::ACC_RANGE_B: next_den = acc_pkg::LAD_DEN_B;
         acc_pkg::ACC_RANGE_C: next_den = acc_pkg::LAD_DEN_C;
         default: next_den = acc_pkg::LAD_DEN_D;
      endcase
   end
   acc_pkg::acc_analog_s next_setup;
   // analog front end setup assembled from the registers
   always_comb
   begin
      next_setup.enable = compEnable;
      next_setup.minusSel = acc_pkg::acc_minus_e'(
         ctlReg[acc_pkg::CTL_MINUS_HI:acc_pkg::CTL_MINUS_LO]);
      next_setup.plusSelPin = ctlReg[acc_pkg::CTL_PLUS];
      next_setup.range = acc_pkg::acc_range_e'(rangeCode);
      next_setup.step = stepCode;
      next_setup.ratioNum = next_num;
      next_setup.ratioDen = next_den;
   end
   // two-flop synchroniser for the analog result
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         compMeta <= 1'b0;
         compSync <= 1'b0;
      end
      else
      begin
         compMeta <= compRaw;
         compSync <= compMeta;
      end
   end
   // registers, written at the completing access edge
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ctlReg <= acc_pkg::CTL_RESET;
         refReg <= acc_pkg::REF_RESET;
      end
      else
      begin
         if (wrCtl)
            ctlReg <= next_ctl;
         if (wrRef)
            refReg <= apbReq.pwdata[7:0];
      end
   end
   // apb answer: ready one cycle after setup
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
      else
      begin
         pready <= setupPhase;
         pslverr <= setupPhase && !hitAny;
         prdata <= setupPhase ? {24'h000000, readByte} : 32'h0000_0000;
      end
   end
   // result sampling, pin drive and event pulses
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         heldResult <= 1'b0;
         resultPrev <= 1'b0;
         comparator_output_pin <= 1'b0;
         comparatorPinOe <= 1'b0;
         compIrq <= 1'b0;
         wakeReq <= 1'b0;
         analogSetup <= '0;
      end
      else
      begin
         heldResult <= next_heldResult;
         resultPrev <= curResult;
         comparator_output_pin <= curResult;
         comparatorPinOe <= refReg[acc_pkg::REF_PIN_OUT];
         compIrq <= resultEdge;
         wakeReq <= resultEdge && powerSave && compEnable
                    && refReg[acc_pkg::REF_WAKE_EN];
         analogSetup <= next_setup;
      end
   end
   // checks
   property p_minus_sel;
      @(posedge mclk) disable iff (!arst_n)
      wrCtl |=> ##1 (analogSetup.minusSel == $past(apbReq.pwdata[3:1], 2));
   endproperty
   a_minus_sel: assert property (p_minus_sel) else $error("minus select wrong");
   property p_plus_sel;
      @(posedge mclk) disable iff (!arst_n)
      wrCtl |=> ##1 (analogSetup.plusSelPin == $past(apbReq.pwdata[0], 2));
   endproperty
   a_plus_sel: assert property (p_plus_sel) else $error("plus select wrong");
   property p_invert;
      @(posedge mclk) disable iff (!arst_n)
      (compEnable && !timerMode) |=>
         (comparator_output_pin == ($past(compSync) ^ $past(ctlReg[acc_pkg::CTL_INVERT])));
   endproperty
   a_invert: assert property (p_invert) else $error("result polarity wrong");
   property p_pin_follow;
      @(posedge mclk) disable iff (!arst_n)
      1'b1 |=> (comparator_output_pin == $past(curResult));
   endproperty
   a_pin_follow: assert property (p_pin_follow) else $error("pin not following result");
   property p_timer_hold;
      @(posedge mclk) disable iff (!arst_n)
      (timerMode && !timer_b_sample_clock) |=> $stable(heldResult);
   endproperty
   a_timer_hold: assert property (p_timer_hold) else $error("sample moved without tick");
   property p_irq;
      @(posedge mclk) disable iff (!arst_n)
      compIrq |-> ($past(curResult) && !$past(resultPrev));
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt without rising result");
   property p_ratio_a;
      @(posedge mclk) disable iff (!arst_n)
      (rangeCode == 2'h0) |=> (analogSetup.ratioDen == 6'h20)
         && (analogSetup.ratioNum == 5'($past(stepCode)) + 5'h09);
   endproperty
   a_ratio_a: assert property (p_ratio_a) else $error("range 00 ratio wrong");
   property p_ratio_c;
      @(posedge mclk) disable iff (!arst_n)
      (rangeCode == 2'h2) |=> (analogSetup.ratioDen == 6'h28)
         && (analogSetup.ratioNum == 5'($past(stepCode)) + 5'h09);
   endproperty
   a_ratio_c: assert property (p_ratio_c) else $error("range 10 ratio wrong");
   property p_enable;
      @(posedge mclk) disable iff (!arst_n)
      !compEnable |-> ##2 (!analogSetup.enable || ctlReg[7]);
   endproperty
   a_enable: assert property (p_enable) else $error("enable not reflected");
   property p_wake;
      @(posedge mclk) disable iff (!arst_n)
      wakeReq |-> ($past(compEnable) && $past(refReg[6]) && $past(powerSave));
   endproperty
   a_wake: assert property (p_wake) else $error("wake without both enables");
   property p_result_ro;
      @(posedge mclk) disable iff (!arst_n)
      wrCtl |=> (ctlReg[6] == 1'b0);
   endproperty
   a_result_ro: assert property (p_result_ro) else $error("result bit was stored");
endmodule
`default_nettype wire

// ---- acc_analog_model.sv ----
// behavioural model of the comparator's analog inputs and reference ladder
`timescale 1ns/100ps
`default_nettype none
module acc_analog_model
(
   input wire acc_pkg::acc_analog_s setup,
   input wire logic [15:0] vPinA,
   input wire logic [15:0] vPlusPin,
   input wire logic [15:0] vPinC,
   input wire logic [15:0] vPinD,
   input wire logic [15:0] vSupply,
   output logic compRaw
);
   localparam int BANDGAP_MV = 1200;
   int ladder;
   int minusV;
   int plusV;
   // ladder level, input selection and the comparison itself, all in millivolts
   // pins are seen as pure analog levels: their digital input buffers are off
   always_comb
   begin
      ladder = (setup.ratioDen == 6'h00) ? 0
               : int'(vSupply) * int'(setup.ratioNum) / int'(setup.ratioDen);
      case (setup.minusSel)
         3'h0: minusV = int'(vPinA);
         3'h1: minusV = int'(vPlusPin);
         3'h2: minusV = BANDGAP_MV;
         3'h3: minusV = ladder;
         3'h4: minusV = int'(vPinC);
         3'h5: minusV = int'(vPinD);
         default: minusV = 65535;
      endcase
      plusV = setup.plusSelPin ? int'(vPlusPin) : ladder;
      compRaw = (plusV > minusV);
   end
endmodule
`default_nettype wire

// ---- tb.sv ----
// self-checking testbench for the analog comparator control block
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic mclk = 1'b0;
   logic arst_n = 1'b0;
   acc_pkg::acc_apb_req_s apbReq = '0;
   logic [31:0] prdata;
   logic pready, pslverr, compRaw, comparator_output_pin, comparatorPinOe, compIrq, wakeReq;
   logic timerTick = 1'b0;
   logic powerSave = 1'b0;
   acc_pkg::acc_analog_s analogSetup;
   logic [15:0] vPinA = 16'h0BB8;
   int errors = 0;
   int checked = 0;
   int irqs = 0;
   int wakes = 0;
   logic [31:0] rd;
   logic err;
   logic [7:0] s;
   always #2 mclk = ~mclk;
   // counts of interrupt and wake pulses
   always @(posedge mclk)
   begin
      if (compIrq === 1'b1) irqs++;
      if (wakeReq === 1'b1) wakes++;
   end
   acc_comparator_control dut_u (.mclk(mclk), .arst_n(arst_n), .apbReq(apbReq), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .compRaw(compRaw),
      .timer_b_sample_clock(timerTick),
      .powerSave(powerSave), .analogSetup(analogSetup),
      .comparator_output_pin(comparator_output_pin),
      .comparatorPinOe(comparatorPinOe), .compIrq(compIrq), .wakeReq(wakeReq));
   acc_analog_model model_u (.setup(analogSetup), .vPinA(vPinA), .vPlusPin(16'h0000),
      .vPinC(16'h0FA0), .vPinD(16'h0FA0), .vSupply(16'h0FA0), .compRaw(compRaw));
   // verdict and end of run
   task automatic close_out;
   begin
      if (errors == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   end
   endtask
   // compare and report
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
   begin
      checked++;
      if (got !== exp)
      begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   end
   endtask
   // one apb transfer, waiting for pready under a bound
   task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
      int n;
   begin
      @(posedge mclk);
      apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: {24'h000000, d}};
      @(posedge mclk);
      apbReq.penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      apbReq.psel <= 1'b0;
      apbReq.penable <= 1'b0;
      if (pready !== 1'b1)
      begin
         errors++;
         close_out();
      end
   end
   endtask
   // timer sample pulse then settle
   task automatic tick;
   begin
      @(posedge mclk);
      timerTick <= 1'b1;
      @(posedge mclk);
      timerTick <= 1'b0;
      repeat (4) @(posedge mclk);
   end
   endtask
   // expected ladder ratio {num, den} from a setup value
   function automatic logic [31:0] expRatio(input logic [7:0] v);
      logic [4:0] num;
      logic [5:0] den;
   begin
      num = {1'b0, v[3:0]} + (v[4] ? 5'h01 : 5'h09);
      den = v[5] ? (v[4] ? 6'h20 : 6'h28) : (v[4] ? 6'h18 : 6'h20);
      return {21'h000000, num, den};
   end
   endfunction
   // main sequence
   initial
   begin
      void'($urandom(32'h00009D40));
      repeat (3) @(posedge mclk);
      arst_n <= 1'b1;
      bus(1'b0, 12'h000, 8'h00);
      chk(rd, 32'h0);
      bus(1'b1, 12'h008, 8'hFF);
      chk({31'h0, err}, 32'h1);
      bus(1'b0, 12'h008, 8'h00);
      chk(rd, 32'h0);
      chk({31'h0, err}, 32'h1);
      bus(1'b0, 12'h000, 8'h00);
      chk(rd, 32'h0);
      for (int i = 0; i < 18; i++)
      begin
         s = (i == 0) ? 8'h09 : (i == 1) ? 8'hAD : 8'($urandom());
         bus(1'b1, 12'h004, s);
         bus(1'b0, 12'h004, 8'h00);
         chk(rd, {24'h000000, s});
         chk({analogSetup.range, analogSetup.step}, s[5:0]);
         chk({analogSetup.ratioNum, analogSetup.ratioDen}, expRatio(s));
      end
      for (int c = 0; c < 12; c++)
      begin
         s = {4'h8, 3'(c >> 1), 1'(c)};
         bus(1'b1, 12'h000, s);
         repeat (2) @(posedge mclk);
         chk(analogSetup[21:17], {s[7], s[3:0]});
      end
      bus(1'b1, 12'h004, 8'h89);
      bus(1'b1, 12'h000, 8'hD0);
      vPinA <= 16'h03E8;
      repeat (5) @(posedge mclk);
      bus(1'b0, 12'h000, 8'h00);
      chk(rd, 32'h90);
      chk(comparator_output_pin, 1'b0);
      bus(1'b1, 12'h000, 8'h80);
      repeat (5) @(posedge mclk);
      bus(1'b0, 12'h000, 8'h00);
      chk(rd, 32'hC0);
      chk({comparatorPinOe, comparator_output_pin}, 2'b11);
      vPinA <= 16'h0BB8;
      bus(1'b1, 12'h004, 8'hC9);
      powerSave <= 1'b1;
      repeat (6) @(posedge mclk);
      irqs = 0;
      wakes = 0;
      vPinA <= 16'h03E8;
      repeat (6) @(posedge mclk);
      chk(irqs, 1);
      chk(wakes, 1);
      bus(1'b1, 12'h004, 8'h89);
      vPinA <= 16'h0BB8;
      repeat (6) @(posedge mclk);
      vPinA <= 16'h03E8;
      repeat (6) @(posedge mclk);
      chk(irqs, 2);
      chk(wakes, 1);
      vPinA <= 16'h0BB8;
      bus(1'b1, 12'h000, 8'hA0);
      repeat (5) @(posedge mclk);
      tick();
      vPinA <= 16'h03E8;
      repeat (6) @(posedge mclk);
      chk(comparator_output_pin, 1'b0);
      tick();
      chk(comparator_output_pin, 1'b1);
      close_out();
   end
endmodule
`default_nettype wire
